// ===== hdl/sars_consts.svh
`ifndef SARS_CONSTS_SVH
`define SARS_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and result format
// ----------------------------------------------------------------------
`define SARS_CLK_MHZ 125
`define SARS_RES_BITS 18
`define SARS_FIFO_DEPTH 16

// ----------------------------------------------------------------------
// Link timing in ns
// ----------------------------------------------------------------------
`define SARS_T_CONV_NS 500
`define SARS_T_CONV_MAX_NS 710
`define SARS_T_TRIG_HI_NS 10
`define SARS_T_DIN_HI_NS 10
`define SARS_T_TRIG_LO_NS 20

// Serial clock half period in system clocks (host divider)
`define SARS_SCLK_HALF_CYC 8

// Least time in ns to whole cycles, rounded up
`define SARS_CYC_MIN(ns) ((((ns) * `SARS_CLK_MHZ) + 999) / 1000)

`endif

// ===== hdl/sars_pkg.sv
package sars_pkg;

    // Interface style chosen by the host
    typedef enum logic [1:0] {
        SARS_3WIRE,
        SARS_4WIRE,
        SARS_DAISY
    } sars_mode_t;

    // Converter-side sequencing
    typedef enum {
        SARS_D_ACQ,
        SARS_D_CONV
    } sars_dev_state_t;

    // Host-side sequencing
    typedef enum {
        SARS_H_IDLE,
        SARS_H_TRIG,
        SARS_H_CONV,
        SARS_H_LOW,
        SARS_H_HIGH,
        SARS_H_END
    } sars_host_state_t;

endpackage

// ===== hdl/sars_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Serial link between host and converter
// ----------------------------------------------------------------------
interface sars_link_if;
    logic conv_trigger;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;

    modport dev (
        input conv_trigger,
        input sclk,
        input din,
        output dout,
        output dout_oe
    );

    modport host (
        output conv_trigger,
        output sclk,
        output din,
        input dout,
        input dout_oe
    );
endinterface

// ===== hdl/sars_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Result FIFO, DEPTH a power of two
// ----------------------------------------------------------------------
module sars_fifo #(
    parameter int W = 18,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    import sars_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic full;
    logic empty;
    logic [AW:0] next_wr;
    logic [AW:0] next_rd;
    logic next_full;
    logic next_empty;
    logic do_wr;
    logic do_rd;

    // Pointers carry one extra wrap bit so full and empty differ
    always_comb begin
        do_wr = in_valid_i & ~full;
        do_rd = out_ready_i & ~empty;
        next_wr = wr + {{AW{1'b0}}, do_wr};
        next_rd = rd + {{AW{1'b0}}, do_rd};
        next_empty = (next_wr == next_rd);
        next_full = (next_wr[AW] != next_rd[AW]) && (next_wr[AW-1:0] == next_rd[AW-1:0]);
    end

    // Flags are registered so both ready and valid come from flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr <= '0;
            rd <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else if (ce_i) begin
            wr <= next_wr;
            rd <= next_rd;
            full <= next_full;
            empty <= next_empty;
        end
    end

    // Storage needs no reset; unread slots are never shown
    always_ff @(posedge sys_clk_i) begin
        if (ce_i && do_wr) begin
            mem[wr[AW-1:0]] <= in_data_i;
        end
    end

    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rd[AW-1:0]];
endmodule

// ===== hdl/sars_device.sv
`timescale 1ns/1ps
`include "sars_consts.svh"
// Operation
// R1: 3-wire host frames read-out with trigger
// R2: 4-wire host frames read-out with serial input
// R3: 3-wire: trigger low drives result MSB out
// R4: 4-wire: serial input low drives MSB out
// R5: Each serial clock fall advances output bit
// R6: 3-wire: release output on trigger high/last
// R7: 4-wire: release output on input high/last
// R8: 3-wire trigger high pulse at least 10 ns
// R9: 4-wire deselect high at least 10 ns
// R10: 4-wire trigger low 20 ns between starts
// R11: Input high at trigger rise selects chip-select
// R12: Input low at trigger rise selects daisy
// R13: Serial clock stable around trigger rise in daisy
// R14: Daisy: capture serial input on clock fall
// R15: Busy variant keeps the same sequencing
// R16: Latch serial input at trigger rise
// R17: Input tied to trigger means daisy chain
// R18: Busy option prepends one busy bit
// R19: Results are two's complement
// R20: Host waits worst-case conversion before reading
// R21: Daisy chain nearest result arrives first

// ----------------------------------------------------------------------
// Converter end: conversion timing and serial read-out
// ----------------------------------------------------------------------
module sars_device #(
    parameter int RES_W = `SARS_RES_BITS,
    parameter int CONV_CYC = `SARS_CYC_MIN(`SARS_T_CONV_NS)
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic busy_en_i,
    input wire logic [RES_W-1:0] sample_i,
    output logic conv_busy_o,
    output sars_pkg::sars_mode_t mode_o,
    sars_link_if.dev link
);
    import sars_pkg::*;

    localparam int CW = $clog2(CONV_CYC + 1);
    localparam int LW = $clog2(RES_W + 2);

    // ------------------------------------------------------------------
    // Pin synchronisers: bit 0 trigger, bit 1 serial clock, bit 2 input
    // ------------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic trig;
    logic din;
    logic din_prev;
    logic trig_rise;
    logic sclk_fall;

    // Third stage serves edge finding and the earlier input sample; stage one feeds stage two only
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 3'h5;
            sync2 <= 3'h5;
            sync3 <= 3'h5;
        end else if (ce_i) begin
            sync1 <= {link.din, link.sclk, link.conv_trigger};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_comb begin
        trig = sync2[0];
        din = sync2[2];
        din_prev = sync3[2];
        trig_rise = sync2[0] & ~sync3[0];
        sclk_fall = ~sync2[1] & sync3[1];
    end

    // ------------------------------------------------------------------
    // Conversion and shift state
    // ------------------------------------------------------------------
    sars_dev_state_t st;
    sars_dev_state_t next_st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic daisy;
    logic next_daisy;
    logic [RES_W-1:0] held;
    logic [RES_W-1:0] next_held;
    logic [RES_W:0] sh;
    logic [RES_W:0] next_sh;
    logic busy_q;
    logic next_busy_q;
    logic [LW-1:0] left;
    logic [LW-1:0] next_left;
    logic oe;
    logic next_oe;
    logic dout;
    logic next_dout;
    logic sel;
    logic sel_q;
    logic conv_busy;
    logic next_conv_busy;
    logic four_wire;
    logic next_four_wire;
    sars_mode_t mode;
    sars_mode_t next_mode;

    // Chip-select modes: trigger low (3-wire) or serial input low (4-wire)
    always_comb begin
        if (daisy) begin
            sel = ~trig;
        end else begin
            sel = ~trig | ~din; // R1 R2
        end
    end

    // Next-state logic for conversion, framing and shifting
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_daisy = daisy;
        next_held = held;
        next_sh = sh;
        next_busy_q = busy_q;
        next_left = left;
        next_oe = oe;
        next_dout = dout;
        next_four_wire = four_wire;
        // Deselect always releases the output
        if (!sel) begin
            next_oe = 1'b0; // R6 R7
        end
        case (st)
            SARS_D_ACQ: begin
                if (trig_rise) begin
                    // Input sampled one stage earlier, so a tied input reads low
                    next_daisy = ~din_prev; // R16 R17
                    next_four_wire = 1'b0;
                    next_st = SARS_D_CONV;
                    next_cnt = CW'(CONV_CYC - 1);
                    next_held = sample_i; // R19
                    next_left = '0;
                    next_oe = 1'b0; // R6
                end else if (sel && !sel_q && (daisy || left != '0)) begin
                    next_oe = 1'b1; // R3 R4
                    next_dout = busy_q ? sh[RES_W] : sh[RES_W-1];
                    next_four_wire = ~daisy & trig;
                end else if (sclk_fall && oe) begin
                    // Daisy keeps shifting so upstream bits pass through
                    next_sh = {sh[RES_W-1:0], din}; // R5 R14
                    next_dout = busy_q ? sh[RES_W-1] : sh[RES_W-2]; // R5
                    if (!daisy) begin
                        next_left = left - LW'(1);
                        if (left == LW'(1)) begin
                            next_oe = 1'b0; // R6 R7
                        end
                    end
                end
            end
            SARS_D_CONV: begin
                next_cnt = cnt - CW'(1);
                // Busy variant in chip-select styles: selected output reads low until done
                next_oe = sel & busy_en_i & ~daisy; // R15
                next_dout = 1'b0;
                if (cnt == '0) begin
                    next_st = SARS_D_ACQ;
                    next_busy_q = busy_en_i;
                    if (busy_en_i) begin
                        next_sh = {1'b1, held}; // R18
                        next_left = LW'(RES_W + 1);
                        next_dout = 1'b1;
                    end else begin
                        next_sh = {1'b0, held}; // R19
                        next_left = LW'(RES_W);
                        next_dout = held[RES_W-1];
                    end
                end
            end
            default: begin
                next_st = SARS_D_ACQ;
            end
        endcase
        next_conv_busy = (next_st == SARS_D_CONV);
        // Style is registered so the output comes straight from a flop
        if (next_daisy) begin
            next_mode = SARS_DAISY;
        end else if (next_four_wire) begin
            next_mode = SARS_4WIRE;
        end else begin
            next_mode = SARS_3WIRE;
        end
    end

    // Registers; the clock enable freezes everything
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= SARS_D_ACQ;
            cnt <= '0;
            daisy <= 1'b0;
            held <= '0;
            sh <= '0;
            busy_q <= 1'b0;
            left <= '0;
            oe <= 1'b0;
            dout <= 1'b0;
            sel_q <= 1'b0;
            conv_busy <= 1'b0;
            four_wire <= 1'b0;
            mode <= SARS_3WIRE;
        end else if (ce_i) begin
            st <= next_st;
            cnt <= next_cnt;
            daisy <= next_daisy;
            held <= next_held;
            sh <= next_sh;
            busy_q <= next_busy_q;
            left <= next_left;
            oe <= next_oe;
            dout <= next_dout;
            sel_q <= sel;
            conv_busy <= next_conv_busy;
            four_wire <= next_four_wire;
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    always_comb begin
        link.dout = dout;
        link.dout_oe = oe;
        conv_busy_o = conv_busy;
        mode_o = mode;
    end
endmodule

// ===== hdl/sars_host.sv
`timescale 1ns/1ps
`include "sars_consts.svh"
// ----------------------------------------------------------------------
// Host end: triggers conversions, clocks results into a FIFO
// ----------------------------------------------------------------------
module sars_host #(
    parameter int RES_W = `SARS_RES_BITS,
    parameter int N_DEV = 1,
    parameter int SCLK_HALF = `SARS_SCLK_HALF_CYC,
    parameter int FIFO_DEPTH = `SARS_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic run_i,
    input wire logic busy_en_i,
    input wire sars_pkg::sars_mode_t mode_i,
    output logic [RES_W-1:0] res_data_o,
    output logic res_valid_o,
    input wire logic res_ready_i,
    sars_link_if.host link
);
    import sars_pkg::*;

    localparam int CW = 8;
    localparam int TRIG_HI = `SARS_CYC_MIN(`SARS_T_TRIG_HI_NS);
    localparam int CONV_WAIT = `SARS_CYC_MIN(`SARS_T_CONV_MAX_NS);
    localparam int TLO = `SARS_CYC_MIN(`SARS_T_TRIG_LO_NS);
    localparam int DHI = `SARS_CYC_MIN(`SARS_T_DIN_HI_NS);
    localparam int GAP = (TLO > DHI) ? TLO : DHI;
    localparam int BW = $clog2(RES_W + 2);
    localparam int WW = $clog2(N_DEV + 1);

    // ------------------------------------------------------------------
    // Serial output synchroniser
    // ------------------------------------------------------------------
    logic dout_s1;
    logic dout_s2;

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_s1 <= 1'b0;
            dout_s2 <= 1'b0;
        end else if (ce_i) begin
            dout_s1 <= link.dout;
            dout_s2 <= dout_s1;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    sars_host_state_t st;
    sars_host_state_t next_st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [BW-1:0] bidx;
    logic [BW-1:0] next_bidx;
    logic [WW-1:0] widx;
    logic [WW-1:0] next_widx;
    logic [RES_W-1:0] acc;
    logic [RES_W-1:0] next_acc;
    logic trig;
    logic next_trig;
    logic sclk;
    logic next_sclk;
    logic din;
    logic next_din;
    logic push;
    logic fifo_ready;
    logic [BW-1:0] last_bit;
    logic cs_idle;

    always_comb begin
        last_bit = busy_en_i ? BW'(RES_W) : BW'(RES_W - 1);
        cs_idle = (mode_i != SARS_DAISY); // R11 R12
        next_st = st;
        next_cnt = cnt;
        next_bidx = bidx;
        next_widx = widx;
        next_acc = acc;
        next_trig = trig;
        next_sclk = sclk;
        next_din = din;
        push = 1'b0;
        case (st)
            SARS_H_IDLE: begin
                next_din = cs_idle;
                next_sclk = 1'b0; // R13
                if (cnt != '0) begin
                    next_cnt = cnt - CW'(1);
                end else if (run_i && din == cs_idle) begin // R11 R12
                    next_st = SARS_H_TRIG;
                    next_trig = 1'b1;
                    next_cnt = CW'(TRIG_HI - 1); // R8
                end
            end
            SARS_H_TRIG: begin
                next_cnt = cnt - CW'(1);
                if (cnt == '0) begin
                    next_st = SARS_H_CONV;
                    next_cnt = CW'(CONV_WAIT - 1);
                end
            end
            SARS_H_CONV: begin
                next_cnt = cnt - CW'(1);
                if (cnt == '0) begin
                    // Read only after the slowest conversion is over
                    next_st = SARS_H_LOW; // R20
                    next_cnt = CW'(SCLK_HALF - 1);
                    next_bidx = '0;
                    next_widx = '0;
                    if (mode_i == SARS_4WIRE) begin
                        next_din = 1'b0; // R2
                    end else begin
                        next_trig = 1'b0; // R1
                    end
                end
            end
            SARS_H_LOW: begin
                if (cnt != '0) begin
                    next_cnt = cnt - CW'(1);
                end else if (bidx != last_bit || fifo_ready) begin
                    // Sample before the falling edge replaces the bit
                    next_acc = {acc[RES_W-2:0], dout_s2}; // R5
                    next_sclk = 1'b1;
                    next_st = SARS_H_HIGH;
                    next_cnt = CW'(SCLK_HALF - 1);
                    next_bidx = bidx + BW'(1);
                    if (bidx == last_bit) begin
                        // Busy bit falls off the top of the accumulator
                        push = 1'b1; // R18 R21
                        next_bidx = '0;
                        next_widx = widx + WW'(1);
                    end
                end
            end
            SARS_H_HIGH: begin
                next_cnt = cnt - CW'(1);
                if (cnt == '0) begin
                    next_sclk = 1'b0; // R5
                    next_cnt = CW'(SCLK_HALF - 1);
                    next_st = (widx == WW'(N_DEV)) ? SARS_H_END : SARS_H_LOW;
                end
            end
            SARS_H_END: begin
                next_cnt = cnt - CW'(1);
                if (cnt == '0) begin
                    // 4-wire deselect; trigger low gap before the next start
                    next_din = cs_idle; // R9
                    next_trig = 1'b0; // R10
                    next_cnt = CW'(GAP);
                    next_st = SARS_H_IDLE;
                end
            end
            default: begin
                next_st = SARS_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= SARS_H_IDLE;
            cnt <= CW'(GAP);
            bidx <= '0;
            widx <= '0;
            acc <= '0;
            trig <= 1'b0;
            sclk <= 1'b0;
            din <= 1'b1;
        end else if (ce_i) begin
            st <= next_st;
            cnt <= next_cnt;
            bidx <= next_bidx;
            widx <= next_widx;
            acc <= next_acc;
            trig <= next_trig;
            sclk <= next_sclk;
            din <= next_din;
        end
    end

    // A full FIFO holds the serial clock low before a word's last rising edge, stalling the read-out
    sars_fifo #(
        .W(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(push),
        .in_data_i(next_acc),
        .in_ready_o(fifo_ready),
        .out_valid_o(res_valid_o),
        .out_data_o(res_data_o),
        .out_ready_i(res_ready_i)
    );

    always_comb begin
        link.conv_trigger = trig;
        link.sclk = sclk;
        link.din = din;
    end
endmodule

// ===== tb/sars_link_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Link checker: watches the wires between host and converter
// ----------------------------------------------------------------------
module sars_link_sva (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic conv_trigger,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    // Worst-case conversion of 710 ns in whole 8 ns cycles
    localparam int T_WAIT = 89;
    logic trig_q;
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // Cycles the trigger stood high since its last rise; saturates so it never wraps
    always_comb begin
        next_hi_cnt = hi_cnt;
        if (conv_trigger && !trig_q) begin
            next_hi_cnt = 8'h01;
        end else if (conv_trigger && hi_cnt != 8'hff) begin
            next_hi_cnt = hi_cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_q <= 1'b0;
            hi_cnt <= 8'h00;
        end else begin
            trig_q <= conv_trigger;
            hi_cnt <= next_hi_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------------
    sequence s_start;
        $rose(conv_trigger);
    endsequence
    sequence s_clk_quiet;
        !sclk && $stable(sclk) ##1 !sclk;
    endsequence
    sequence s_strap_held;
        $stable(din) ##1 $stable(din);
    endsequence

    property p_sel3;
        $fell(conv_trigger) && $stable(din) && din |-> ##[3:5] dout_oe;
    endproperty
    property p_sel4;
        $fell(din) && conv_trigger |-> ##[3:5] dout_oe;
    endproperty
    property p_shift;
        $rose(sclk) && dout_oe |=> $stable(dout) [*8];
    endproperty
    property p_rel3;
        s_start |-> ##[0:5] !dout_oe;
    endproperty
    property p_rel4;
        $rose(din) |-> ##[0:5] !dout_oe;
    endproperty
    property p_trig_hi;
        s_start |-> conv_trigger [*2];
    endproperty
    property p_desel_hi;
        $rose(din) |-> din [*2];
    endproperty
    property p_trig_lo;
        $fell(conv_trigger) |-> !conv_trigger [*3];
    endproperty
    property p_strap;
        s_start |-> s_strap_held;
    endproperty
    property p_clk_quiet;
        s_start |-> s_clk_quiet;
    endproperty
    property p_wait;
        $rose(sclk) |-> hi_cnt >= T_WAIT;
    endproperty

    a_sel3: assert property (p_sel3) else $error("output not enabled after trigger fall");
    a_sel4: assert property (p_sel4) else $error("output not enabled after select fall");
    a_shift: assert property (p_shift) else $error("data moved while clock high");
    a_rel3: assert property (p_rel3) else $error("output still driven after trigger rise");
    a_rel4: assert property (p_rel4) else $error("output still driven after deselect");
    a_trig_hi: assert property (p_trig_hi) else $error("trigger high pulse too short");
    a_desel_hi: assert property (p_desel_hi) else $error("deselect pulse too short");
    a_trig_lo: assert property (p_trig_lo) else $error("trigger low time too short");
    a_strap: assert property (p_strap) else $error("strap moved at trigger rise");
    a_clk_quiet: assert property (p_clk_quiet) else $error("clock moved at trigger rise");
    a_wait: assert property (p_wait) else $error("read-out before conversion wait");
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "sars_consts.svh"
// ----------------------------------------------------------------------
// Bench: host and converter joined by one link
// ----------------------------------------------------------------------
module tb;
    import sars_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic run = 1'b0;
    logic busy_en = 1'b0;
    logic res_ready = 1'b0;
    sars_mode_t mode = SARS_3WIRE;
    sars_mode_t dev_mode;
    logic [17:0] sample = 18'h20001;
    logic [17:0] res_data;
    logic res_valid;
    logic conv_busy;
    logic busy_q = 1'b0;
    logic [17:0] exp_q[$];
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;

    sars_link_if link ();

    sars_host sars_host_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce), .run_i(run),
        .busy_en_i(busy_en), .mode_i(mode), .res_data_o(res_data), .res_valid_o(res_valid),
        .res_ready_i(res_ready), .link(link));
    sars_device sars_device_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ce_i(ce),
        .busy_en_i(busy_en), .sample_i(sample), .conv_busy_o(conv_busy), .mode_o(dev_mode),
        .link(link));
    sars_link_sva sars_link_sva_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .conv_trigger(link.conv_trigger), .sclk(link.sclk), .din(link.din), .dout(link.dout),
        .dout_oe(link.dout_oe));

    always #4 sys_clk = ~sys_clk;

    // Record each sample once the converter has taken it, then move to a new value
    always @(negedge sys_clk) begin
        busy_q <= conv_busy;
        if (conv_busy === 1'b1 && busy_q !== 1'b1) begin
            exp_q.push_back(sample);
            sample <= sample + 18'h1b3c5;
        end
    end

    // Hang guard: the whole run needs roughly 23000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Pop one word and compare it with the oldest sample; an empty queue expects unknown
    task automatic pop_word(input int wait_max);
        int n;
        n = 0;
        while (res_valid !== 1'b1 && n < wait_max) begin
            @(negedge sys_clk);
            n++;
        end
        check("result present", res_valid, 1'b1);
        if (res_valid === 1'b1) begin
            check("result word", res_data, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
            res_ready = 1'b1;
            @(negedge sys_clk);
            res_ready = 1'b0;
            @(negedge sys_clk);
        end
    endtask

    // Let a started frame finish, then every conversion must have come back
    task automatic drain();
        repeat (900) @(negedge sys_clk);
        while (res_valid === 1'b1) pop_word(1);
        check("words left over", exp_q.size(), 0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic reset_state();
        check("output enable in reset", link.dout_oe, 1'b0);
        check("busy in reset", conv_busy, 1'b0);
        check("valid in reset", res_valid, 1'b0);
        check("style in reset", dev_mode, SARS_3WIRE);
    endtask

    // Back-to-back conversions in one style; words return whole and in order
    task automatic run_style(input sars_mode_t m, input logic busy);
        int n;
        mode = m;
        busy_en = busy;
        run = 1'b1;
        n = 0;
        // Busy must stand for the whole internal conversion, counted at falling edges
        wait (conv_busy === 1'b1);
        @(negedge sys_clk);
        while (conv_busy === 1'b1) begin
            n++;
            @(negedge sys_clk);
        end
        check("conversion cycles", n, `SARS_CYC_MIN(`SARS_T_CONV_NS));
        repeat (3) pop_word(1000);
        check("latched style", dev_mode, m);
        run = 1'b0;
        drain();
    endtask

    // Result side stalls: the FIFO fills to 16 and the serial clock must wait
    task automatic fill_and_drain();
        int toggles;
        logic s;
        mode = SARS_4WIRE;
        busy_en = 1'b0;
        run = 1'b1;
        repeat (9000) @(negedge sys_clk);
        run = 1'b0;
        toggles = 0;
        s = link.sclk;
        repeat (600) begin
            @(negedge sys_clk);
            if (link.sclk !== s) toggles++;
            s = link.sclk;
        end
        check("clock edges while full", toggles, 0);
        repeat (16) pop_word(0);
        drain();
    endtask

    // Daisy styles come last: leaving them raises the strap, kept out of the CS runs
    initial begin
        repeat (3) @(negedge sys_clk);
        reset_state();
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        run_style(SARS_3WIRE, 1'b0);
        run_style(SARS_4WIRE, 1'b0);
        run_style(SARS_3WIRE, 1'b1);
        run_style(SARS_4WIRE, 1'b1);
        fill_and_drain();
        run_style(SARS_DAISY, 1'b0);
        run_style(SARS_DAISY, 1'b1);
        report_and_stop();
    end

    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
endmodule
